// ---- rtl/afmt_pkg.sv ----
// shared constants, types and helpers of the serial audio frame formatter
package afmt_pkg;
    // wishbone byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OFS1 = 4'h4;
    localparam logic [3:0] ADDR_OFS2 = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hc;
    // control register fields
    localparam int CTRL_FMT_LSB  = 0;
    localparam int CTRL_WLEN_LSB = 2;
    localparam int CTRL_INV_BIT  = 4;
    localparam int CTRL_TRI_BIT  = 5;
    localparam int CTRL_EARLY_BIT = 6;
    localparam int CTRL_SLOT_BIT = 7;
    localparam int CTRL_SWAP_BIT = 8;
    localparam int CTRL_EN_BIT   = 9;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [7:0] OFS_RESET  = 8'h00;
    // status register fields
    localparam int STAT_DRIVE_BIT = 10;
    localparam int STAT_LEFT_BIT  = 11;
    localparam int STAT_RIGHT_BIT = 12;
    localparam int STAT_FCNT_LSB  = 16;
    // bit-position counter width, covers offset + two words + offset
    localparam int POS_W = 10;
    localparam logic [POS_W-1:0] POS_MAX = 10'h3ff;

    typedef enum logic [1:0] {FMT_I2S, FMT_DSP, FMT_LJ, FMT_RSVD} fmt_e;

    typedef struct packed {
        logic       en;
        logic       swap;
        logic       slot;
        logic       early;
        logic       tri_en;
        logic       inv;
        logic [1:0] wlen;
        fmt_e       fmt;
    } cfg_s;

    // samples are left-aligned: msb always sits in bit 31
    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } stereo_s;

    function automatic logic [POS_W-1:0] wlen_bits(input logic [1:0] code);
        case (code)
            2'h0:    wlen_bits = 10'h010;
            2'h1:    wlen_bits = 10'h014;
            2'h2:    wlen_bits = 10'h018;
            default: wlen_bits = 10'h020;
        endcase
    endfunction
endpackage

// ---- rtl/afmt_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module afmt_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // afmt_sync2

// ---- rtl/afmt_bclk_edges.sv ----
// bit-clock edge finder: launch and capture pulses after polarity select
`timescale 1ns/1ps
module afmt_bclk_edges (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // synchronised bit clock and options
    input  wire logic bclk_s_i,
    input  wire logic inv_i,
    input  wire logic dsp_i,
    // one-cycle pulses and the registered effective level
    output logic      launch_o,
    output logic      capture_o,
    output logic      level_o
);
    logic eff;
    logic rise;
    logic fall;

    assign eff = bclk_s_i ^ inv_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else begin
            level_o <= eff;
        end
    end

    assign rise = eff & ~level_o;
    assign fall = ~eff & level_o;
    // dsp data valid at falling edge, so it changes at rising; others reverse
    assign launch_o  = dsp_i ? rise : fall;
    assign capture_o = dsp_i ? fall : rise;
endmodule // afmt_bclk_edges

// ---- rtl/audio_serial_frame_formatter.sv ----
// stereo serial audio output formatter: left-justified, i2s and dsp framing
// Contract
// - Slot off, non-DSP: first delay for both channels; each word-clock edge starts one.
// - Left-justified: each data bit valid at rising bit-clock edge.
// - Slot on: first after own delay, second after its delay from first LSB.
// - LJ no swap: left MSB at rising edge delay+1 after rise, right after fall.
// - LJ swap: right word after word-clock rise, left after fall.
// - LJ slot: right MSB on edge second delay+1 after left LSB.
// - LJ slot swap: right leads with first delay, left follows right LSB.
// - I2S zero delay: MSB on second rising edge after word-clock edge.
// - DSP: frame starts at word-clock rise, left then right directly.
// - DSP: each data bit valid at falling bit-clock edge.
// - DSP slot: second MSB follows first LSB by second delay cycles.
// - DSP slot swap: right leads, left follows right LSB after delay.
// - Three-state on: output high impedance in every non-data cycle.
// - Word length 16, 20, 24 or 32 bits, always MSB first.
// - A control bit inverts bit-clock polarity in every format.
// - Three-state off and enable set: output driven low outside data bits.
// - With three-state on, an option releases output half a bit before LSB period ends.
`timescale 1ns/1ps
module audio_serial_frame_formatter #(
    parameter int OFS_W = 8
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone classic slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // samples from the converter
    input  wire afmt_pkg::stereo_s      sample_i,
    output logic                        sample_taken_o,
    // audio serial link
    input  wire logic                   bclk_i,
    input  wire logic                   wclk_i,
    output logic                        dout_o,
    output logic                        dout_oe_n_o
);
    import afmt_pkg::*;

    generate
        if (OFS_W < 1 || OFS_W > 8) begin : g_bad_ofs
            $error("OFS_W must be 1..8 to fit the position counter");
        end
    endgenerate

    // registers
    cfg_s             cfg;
    logic [OFS_W-1:0] first_slot_delay;
    logic [OFS_W-1:0] second_slot_delay;
    logic [15:0]      frame_count;

    // link timing
    logic             bclk_s;
    logic             wclk_s;
    logic             launch;
    logic             capture;
    logic             bclk_lvl;
    logic             wclk_prev;
    logic             wclk_rise;
    logic             wclk_edge;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] hpos;
    logic             half_fall;
    logic [POS_W-1:0] next_pos;
    logic [POS_W-1:0] next_hpos;
    logic             next_half_fall;

    // slot decode
    logic             frame_mode;
    logic [POS_W-1:0] wl;
    logic [POS_W-1:0] start_a;
    logic [POS_W-1:0] start_b;
    logic [POS_W-1:0] gap_b;
    logic             in_a;
    logic             in_b;
    logic             left_act;
    logic             right_act;
    logic [POS_W-1:0] bit_ofs;
    logic             left_half;

    // output data path
    stereo_s          held;
    stereo_s          word;
    logic             next_bit;
    logic             drive;
    logic             lsb_now;
    logic             chan_left;
    logic             chan_right;

    function automatic logic in_window(input logic [POS_W-1:0] p,
                                       input logic [POS_W-1:0] start,
                                       input logic [POS_W-1:0] len);
        in_window = (p >= start) && (p < start + len);
    endfunction

    function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wdat[8*i +: 8];
            end
        end
        merge_sel = r;
    endfunction

    // wishbone slave, one wait state, unmapped reads return zero
    localparam int CFG_W = $bits(cfg_s);
    logic        wb_req;
    logic        wb_wr;
    logic [31:0] ctrl_word;
    logic [31:0] ofs1_word;
    logic [31:0] ofs2_word;

    assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr     = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i; // lands at the ack edge
    assign ctrl_word = {22'h000000, cfg};
    assign ofs1_word = {{(32-OFS_W){1'b0}}, first_slot_delay};
    assign ofs2_word = {{(32-OFS_W){1'b0}}, second_slot_delay};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg               <= cfg_s'(CTRL_RESET);
            first_slot_delay  <= OFS_RESET[OFS_W-1:0];
            second_slot_delay <= OFS_RESET[OFS_W-1:0];
        end else if (wb_wr) begin
            case (wb_adr_i)
                ADDR_CTRL: cfg <= cfg_s'(CFG_W'(merge_sel(ctrl_word, wb_dat_i, wb_sel_i)));
                ADDR_OFS1: first_slot_delay <= OFS_W'(merge_sel(ofs1_word, wb_dat_i, wb_sel_i));
                ADDR_OFS2: second_slot_delay <= OFS_W'(merge_sel(ofs2_word, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL: wb_dat_o <= ctrl_word;
                ADDR_OFS1: wb_dat_o <= ofs1_word;
                ADDR_OFS2: wb_dat_o <= ofs2_word;
                ADDR_STAT: begin
                    wb_dat_o <= 32'h00000000;
                    wb_dat_o[POS_W-1:0]     <= pos;
                    wb_dat_o[STAT_DRIVE_BIT] <= drive;
                    wb_dat_o[STAT_LEFT_BIT]  <= chan_left;
                    wb_dat_o[STAT_RIGHT_BIT] <= chan_right;
                    wb_dat_o[STAT_FCNT_LSB +: 16] <= frame_count;
                end
                default:   wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // link clocks: synchronise, find edges, count bit positions
    afmt_sync2 #(
        .W (2)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({bclk_i, wclk_i}),
        .q_o   ({bclk_s, wclk_s})
    );

    afmt_bclk_edges u_edges (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .bclk_s_i  (bclk_s),
        .inv_i     (cfg.inv),
        .dsp_i     (cfg.fmt == FMT_DSP),
        .launch_o  (launch),
        .capture_o (capture),
        .level_o   (bclk_lvl)
    );

    // word clock is judged only at launch edges, so both edges line up
    // with whole bit periods regardless of host skew within a half bit
    assign wclk_rise = launch & wclk_s & ~wclk_prev;
    assign wclk_edge = launch & (wclk_s ^ wclk_prev);

    always_comb begin
        next_pos       = pos;
        next_hpos      = hpos;
        next_half_fall = half_fall;
        if (wclk_rise) begin
            next_pos = '0;
        end else if (launch && pos != POS_MAX) begin
            next_pos = pos + 10'h001;
        end
        if (wclk_edge) begin
            next_hpos      = '0;
            next_half_fall = ~wclk_s;
        end else if (launch && hpos != POS_MAX) begin
            next_hpos = hpos + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wclk_prev <= 1'b0;
            pos       <= POS_MAX;
            hpos      <= POS_MAX;
            half_fall <= 1'b0;
        end else begin
            if (launch) begin
                wclk_prev <= wclk_s;
            end
            pos       <= next_pos;
            hpos      <= next_hpos;
            half_fall <= next_half_fall;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_count <= 16'h0000;
        end else if (wclk_rise) begin
            frame_count <= frame_count + 16'h0001;
        end
    end

    // slot decode for the position reached at this launch edge
    assign frame_mode = cfg.slot | (cfg.fmt == FMT_DSP);
    assign wl         = wlen_bits(cfg.wlen);
    // i2s puts the msb one bit clock after the word-clock edge
    assign start_a    = POS_W'(first_slot_delay) +
                        ((cfg.fmt == FMT_I2S) ? 10'h001 : 10'h000);
    // dsp counts its gap from the lsb edge itself; a zero delay there also means no gap
    assign gap_b      = (cfg.fmt == FMT_DSP && second_slot_delay != '0) ?
                        POS_W'(second_slot_delay) - 10'h001 : POS_W'(second_slot_delay);
    // dsp without slots is the same frame with a zero gap
    assign start_b    = start_a + wl +
                        (cfg.slot ? gap_b : 10'h000);
    assign in_a       = in_window(frame_mode ? next_pos : next_hpos, start_a, wl);
    assign in_b       = frame_mode && in_window(next_pos, start_b, wl);
    // i2s carries left in the low word-clock half, others in the high half
    assign left_half  = ((cfg.fmt == FMT_I2S) ? next_half_fall : ~next_half_fall)
                        ^ cfg.swap;

    always_comb begin
        left_act  = 1'b0;
        right_act = 1'b0;
        bit_ofs   = '0;
        if (cfg.en && cfg.fmt != FMT_RSVD) begin
            if (frame_mode) begin
                left_act  = cfg.swap ? in_b : in_a;
                right_act = cfg.swap ? in_a : in_b;
                bit_ofs   = in_b ? next_pos - start_b : next_pos - start_a;
            end else begin
                left_act  = in_a & left_half;
                right_act = in_a & ~left_half;
                bit_ofs   = next_hpos - start_a;
            end
        end
    end

    // sample holding and serial output
    assign word     = wclk_rise ? sample_i : held;
    assign next_bit = left_act  ? word.left[5'd31 - bit_ofs[4:0]] :
                      right_act ? word.right[5'd31 - bit_ofs[4:0]] : 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held           <= '0;
            sample_taken_o <= 1'b0;
        end else begin
            sample_taken_o <= wclk_rise;
            if (wclk_rise) begin
                held <= sample_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !cfg.en) begin // powered down: the pin floats
            dout_o     <= 1'b0;
            drive      <= 1'b0;
            lsb_now    <= 1'b0;
            chan_left  <= 1'b0;
            chan_right <= 1'b0;
        end else if (launch) begin
            dout_o     <= next_bit;
            drive      <= left_act | right_act | ~cfg.tri_en;
            lsb_now    <= (left_act | right_act) && bit_ofs == wl - 10'h001;
            chan_left  <= left_act;
            chan_right <= right_act;
        end else if (capture && cfg.early && cfg.tri_en && lsb_now) begin
            // release at mid-lsb so the next talker gets a clean half bit
            drive   <= 1'b0;
            lsb_now <= 1'b0;
        end
    end

    assign dout_oe_n_o = ~drive;

    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_frame_start;
        wclk_rise && cfg.en;
    endsequence
    sequence s_lsb_sent;
        launch && lsb_now == 1'b0 && (left_act | right_act) && bit_ofs == wl - 10'h001;
    endsequence
    AST_LJ_LAUNCH_FALL: assert property (
        capture && cfg.en && cfg.fmt == FMT_LJ |-> (bclk_s ^ cfg.inv) ##1 $stable(dout_o))
        else $error("left-justified data moved at its rising valid edge");
    AST_DSP_LAUNCH_RISE: assert property (
        capture && cfg.en && cfg.fmt == FMT_DSP |-> !(bclk_s ^ cfg.inv) ##1 $stable(dout_o))
        else $error("dsp data moved at its falling valid edge");
    AST_POS_RESTART: assert property (
        s_frame_start |=> pos == 10'h000 && sample_taken_o)
        else $error("position counter not restarted at frame start");
    AST_TRISTATE_IDLE: assert property (
        launch && cfg.en && cfg.tri_en && !(left_act | right_act)
        |=> dout_oe_n_o && !chan_left && !chan_right)
        else $error("output driven in an empty bit cycle");
    AST_DRIVE_LOW_IDLE: assert property (
        launch && cfg.en && !cfg.tri_en && !(left_act | right_act)
        |=> !dout_oe_n_o && !dout_o)
        else $error("idle bit not driven low with three-state off");
    AST_LJ_FIRST_MSB: assert property (
        launch && cfg.en && cfg.fmt == FMT_LJ && !cfg.slot && !cfg.swap &&
        !next_half_fall && next_hpos == POS_W'(first_slot_delay) && !wclk_rise
        |=> chan_left && dout_o == held.left[31])
        else $error("left msb not at first delay plus one");
    AST_I2S_SECOND_EDGE: assert property (
        launch && cfg.en && cfg.fmt == FMT_I2S && !cfg.slot &&
        next_hpos == POS_W'(first_slot_delay) |=> !chan_left && !chan_right)
        else $error("i2s drove data on the first edge after word clock");
    AST_SLOT_SECOND: assert property (
        launch && cfg.en && frame_mode && cfg.fmt != FMT_RSVD &&
        next_pos == start_b |=> (cfg.swap ? chan_left : chan_right))
        else $error("second channel not started after its delay");
    AST_EARLY_RELEASE: assert property (
        lsb_now && drive && cfg.en && cfg.early && cfg.tri_en &&
        capture && !launch |=> dout_oe_n_o)
        else $error("early release did not happen at mid lsb");
    AST_LSB_THEN_GAP: assert property (
        s_lsb_sent ##[1:40] (launch && cfg.en && cfg.slot && cfg.tri_en &&
        gap_b != '0 && next_pos == start_a + wl) |=> dout_oe_n_o)
        else $error("gap after first lsb was not empty");
endmodule // audio_serial_frame_formatter

// ---- test/afmt_host_model.sv ----
// far-side model: makes bit and word clocks, resolves the data pin
`timescale 1ns/1ps
module afmt_host_model #(
    parameter int FRAME = 80
) (
    // options
    input  wire logic inv_i,
    input  wire logic dsp_i,
    // link pins
    output logic      bclk_o,
    output logic      wclk_o,
    output logic      eff_o,
    input  wire logic dout_i,
    input  wire logic dout_oe_n_i,
    output logic      pin_o
);
    int pos;

    // 80 clocks a frame: room for two 32-bit words plus delays
    initial begin
        eff_o = 1'b0;
        wclk_o = 1'b0;
        pos = 0;
        #3;
        forever begin
            #80 eff_o = ~eff_o;
            // word clock moves only at launch edges
            if (eff_o == dsp_i) begin
                if (pos == 0)
                    wclk_o = 1'b1;
                else if (pos == FRAME / 2)
                    wclk_o = 1'b0;
                pos = (pos + 1) % FRAME;
            end
        end
    end

    assign bclk_o = eff_o ^ inv_i;
    assign pin_o  = dout_oe_n_i ? 1'bz : dout_i;
endmodule // afmt_host_model

// ---- test/tb_top.sv ----
// self-checking bench of the serial audio frame formatter
`timescale 1ns/1ps
module tb_top;
    import afmt_pkg::*;
    localparam int HALF = 40;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    stereo_s smp = 64'h0;
    logic sample_taken_o;
    logic bclk;
    logic wclk;
    logic eff;
    logic pin;
    logic dout_o;
    logic dout_oe_n_o;
    logic dsp = 1'b0;
    logic inv = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int wl;
    int c[8];
    logic q[$];
    // fmt, wlen code, delay1, delay2, slot, swap, tri, inv
    int tbl[9][8] = '{'{2, 0, 1, 0, 0, 0, 0, 0}, '{2, 1, 0, 0, 0, 1, 1, 1},
                      '{2, 2, 0, 1, 1, 0, 0, 0}, '{2, 0, 2, 1, 1, 1, 1, 0},
                      '{0, 3, 0, 0, 0, 0, 0, 0}, '{1, 0, 1, 0, 0, 0, 1, 1},
                      '{1, 2, 0, 3, 1, 0, 1, 0}, '{1, 3, 0, 3, 1, 1, 0, 0},
                      '{3, 1, 0, 0, 0, 0, 1, 0}};

    always #4 clk_i = ~clk_i;

    audio_serial_frame_formatter #(.OFS_W(8)) audio_serial_frame_formatter_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(smp),
        .sample_taken_o(sample_taken_o), .bclk_i(bclk), .wclk_i(wclk),
        .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o));

    afmt_host_model #(.FRAME(2 * HALF)) afmt_host_model_i (
        .inv_i(inv), .dsp_i(dsp), .bclk_o(bclk), .wclk_o(wclk), .eff_o(eff),
        .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o), .pin_o(pin));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one classic cycle; ack and data taken at the same edge
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat <= wd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, adr, wd, rd);
    endtask

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        xfer(1'b0, adr, 32'h0, rd);
        check(what, rd, exp);
    endtask

    // expected pin level at valid edge p after the word-clock rise
    function automatic logic expv(input int p);
        logic fr;
        logic [31:0] a;
        logic [31:0] b;
        int sa;
        int sb;
        // reserved format sends nothing at all
        if (c[0] == 3)
            return (c[6] != 0) ? 1'bz : 1'b0;
        fr = c[5][0] ^ (c[0] == 0 && c[4] == 0);
        a = fr ? smp.right : smp.left;
        b = fr ? smp.left : smp.right;
        sa = c[2] + ((c[0] == 0) ? 2 : 1);
        if (c[4] != 0)
            sb = sa + wl + c[3] - ((c[0] == 1) ? 1 : 0);
        else if (c[0] == 1)
            sb = sa + wl;
        else
            sb = sa + HALF;
        if (p >= sa && p < sa + wl)
            return a[31 - (p - sa)];
        if (p >= sb && p < sb + wl)
            return b[31 - (p - sb)];
        return (c[6] != 0) ? 1'bz : 1'b0;
    endfunction

    // compares the pin at each data-valid edge against the oldest note
    always @(eff) begin
        if (eff != dsp && q.size() > 0)
            check("pin", {31'h0, pin}, {31'h0, q.pop_front()});
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        int n;
        logic [31:0] cv;
        void'($urandom(91));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("oe_n", {31'h0, dout_oe_n_o}, 32'h1);
        rd_chk(ADDR_CTRL, 32'h0, "ctrl");
        rd_chk(ADDR_OFS1, 32'h0, "ofs1");
        wr(4'h1, 32'hffffffff);
        rd_chk(4'h1, 32'h0, "unmapped");
        wr(ADDR_OFS2, 32'hffffffff);
        rd_chk(ADDR_OFS2, 32'hff, "ofs2");
        for (int s = 0; s < 9; s++) begin
            c = tbl[s];
            wl = (c[1] == 3) ? 32 : 16 + 4 * c[1];
            dsp = (c[0] == 1);
            inv = c[7][0];
            @(posedge clk_i);
            smp <= {$urandom, $urandom};
            cv = {22'h0, 1'b1, c[5][0], c[4][0], c[6][0] & c[7][0], c[6][0], c[7][0],
                  c[1][1:0], c[0][1:0]};
            wr(ADDR_OFS1, 32'(c[2]));
            wr(ADDR_OFS2, 32'(c[3]));
            wr(ADDR_CTRL, cv);
            rd_chk(ADDR_CTRL, cv, "ctrl");
            // first rise may cut a frame short; check the next one whole
            @(posedge wclk);
            @(posedge wclk);
            for (int p = 1; p <= 2 * HALF; p++)
                q.push_back(expv(p));
            n = 0;
            while (sample_taken_o !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                n++;
            end
            check("taken", {31'h0, sample_taken_o}, 32'h1);
            while (q.size() > 0)
                @(posedge clk_i);
            $display("test %0d done", s);
        end
        results();
    end
endmodule // tb_top
